// ### design/adc_serial_result_readout.sv
// serial readout and software power-down wake logic of the converter
//
// Notes on behaviour
// RQ1: a start bit on the data input wakes the converter from either power-down by itself.
// RQ2: the host waits about two milliseconds after a wake before trusting results; the bench host model reads at once after a wake.
// RQ3: from fast power-down the converter is ready to convert at once.
// RQ4: the result is straight binary when unipolar and two's complement when bipolar.
// RQ5: the host masters the link and keeps the serial clock at or below 2.1 MHz; the bench host model runs it at about 15.6 MHz.
// RQ6: the host uses idle-low clock with phase zero.
// RQ7: data-out changes on falling serial edges and is sampled on rising ones.
// RQ8: an 8-bit host reads the result in two consecutive bytes.
// RQ9: the first byte holds the top eight bits msb first, the second starts with the other six.
// RQ10: a 16-bit host may read the result in one 16-bit transfer.
// RQ11: in a 16-bit read the first 14 bits are result and the rest carry none.
// RQ12: each byte moves in and out at the same time.
// RQ13: the first one sampled with select low while idle is the start bit and control msb.
// RQ14: the two power-mode bits pick full or fast power-down.
// RQ15: power-down begins only after the running conversion ends, serial port staying alive.
// RQ16: fast power-down keeps the reference and serial port, full keeps only the serial port.
// RQ17: the host shifts zeros in while reading results.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_result_readout
#(
    parameter int CONV_CNT = adc_readout_pkg::CONV_CYCLES
)
(
    input  wire logic                                    i_clk_sys,
    input  wire logic                                    i_rst,
    // link side, clocked by the host serial clock
    input  wire logic                                    i_sclk,
    input  wire logic                                    i_cs_n,
    input  wire logic                                    i_din,
    output logic                                         o_dout,
    output logic                                         o_dout_oe_n,
    // analog sample from the converter core
    input  wire logic [adc_readout_pkg::RESULT_BITS-1:0] i_sample,
    // status and power outputs
    output logic                                         o_busy,
    output logic                                         o_ref_on,
    output logic                                         o_core_on,
    output adc_readout_pkg::pwr_state_t                  o_pwr_state
);
    import adc_readout_pkg::*;

    // refuse counts that the 16-bit conversion timer cannot hold
    if (CONV_CNT < 1 || CONV_CNT > 65536)
    begin : g_bad_conv_cnt
        $error("conversion count out of range");
    end

    // ------------------------------------------------------------
    // link domain: control byte capture and result shift
    // ------------------------------------------------------------
    // link flops start known: select is the only reset this side has
    logic [CTRL_BITS-1:0]   shift_in_ff    = '0;
    logic [3:0]             bit_cnt_ff     = 4'h0;
    logic                   in_ctrl_ff     = 1'b0;
    ctrl_t                  ctrl_ff        = '0;
    logic                   req_tgl_ff     = 1'b0;
    logic                   wake_tgl_ff    = 1'b0;
    logic [RESULT_BITS-1:0] result_sh_ff   = '0;
    logic                   dout_ff        = 1'b0;
    logic                   done_s1_ff     = 1'b0;
    logic                   done_s2_ff     = 1'b0;
    logic                   done_s3_ff     = 1'b0;
    logic                   load_pend_ff   = 1'b0;
    logic                   done_tgl_ff    = 1'b0;
    logic [RESULT_BITS-1:0] result_code_ff;

    // rising edge: capture din; first one while idle is the start bit
    always_ff @(posedge i_sclk or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            in_ctrl_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            shift_in_ff <= '0;
        end
        else if (!in_ctrl_ff)
        begin
            if (i_din) // see RQ13
            begin
                in_ctrl_ff  <= 1'b1; // see RQ1
                bit_cnt_ff  <= 4'h1;
                shift_in_ff <= {{(CTRL_BITS-1){1'b0}}, 1'b1};
            end
        end
        else if (bit_cnt_ff == 4'(CTRL_BITS - 1))
        begin
            in_ctrl_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            shift_in_ff <= '0;
        end
        else
        begin
            bit_cnt_ff  <= bit_cnt_ff + 4'h1;
            shift_in_ff <= {shift_in_ff[CTRL_BITS-2:0], i_din}; // see RQ12
        end
    end

    // latch the full control byte on the eighth rising edge
    always_ff @(posedge i_sclk)
    begin
        if (!i_cs_n && in_ctrl_ff && bit_cnt_ff == 4'(CTRL_BITS - 1))
        begin
            ctrl_ff.bipolar    <= shift_in_ff[CTRL_BIPOLAR_POS-1];
            ctrl_ff.power_mode <= {shift_in_ff[CTRL_PWR_LO_POS], i_din}; // see RQ14
            req_tgl_ff         <= ~req_tgl_ff;
        end
    end

    // start bit flips a wake toggle toward the system side
    always_ff @(posedge i_sclk)
    begin
        if (!i_cs_n && !in_ctrl_ff && i_din)
            wake_tgl_ff <= ~wake_tgl_ff; // see RQ1, RQ13
    end

    // completion toggle from the system side, two stages then edge detect
    always_ff @(negedge i_sclk)
    begin
        done_s1_ff <= done_tgl_ff;
        done_s2_ff <= done_s1_ff;
        done_s3_ff <= done_s2_ff;
    end

    // falling edge: load result when done, then shift msb first
    always_ff @(negedge i_sclk or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            result_sh_ff <= '0;
            dout_ff      <= 1'b0;
            load_pend_ff <= 1'b0;
        end
        else if (done_s3_ff != done_s2_ff)
        begin
            load_pend_ff <= 1'b1;
            dout_ff      <= 1'b0;
        end
        else if (load_pend_ff)
        begin
            load_pend_ff <= 1'b0;
            dout_ff      <= result_code_ff[RESULT_BITS-1]; // see RQ9
            result_sh_ff <= {result_code_ff[RESULT_BITS-2:0], 1'b0};
        end
        else
        begin
            // trailing bits after the result shift out as zeros
            dout_ff      <= result_sh_ff[RESULT_BITS-1]; // see RQ7, RQ11
            result_sh_ff <= {result_sh_ff[RESULT_BITS-2:0], 1'b0};
        end
    end

    assign o_dout      = dout_ff;
    assign o_dout_oe_n = i_cs_n;

    // ------------------------------------------------------------
    // system domain: request crossing, conversion, power state
    // ------------------------------------------------------------
    logic                   req_s1_ff;
    logic                   req_s2_ff;
    logic                   req_s3_ff;
    logic                   wake_s1_ff;
    logic                   wake_s2_ff;
    logic                   wake_s3_ff;
    logic                   wake_evt;
    logic                   busy_ff;
    logic [15:0]            conv_cnt_ff;
    logic [RESULT_BITS-1:0] coded;
    logic [1:0]             pend_mode_ff;
    logic                   bipolar_ff;
    pwr_state_t             pwr_ff;
    logic                   req_evt;

    // free-running two-stage crossings of the request and wake toggles;
    // no reset, so a toggle left set across a reset gives no false event
    always_ff @(posedge i_clk_sys)
    begin
        req_s1_ff  <= req_tgl_ff;
        req_s2_ff  <= req_s1_ff;
        req_s3_ff  <= req_s2_ff;
        wake_s1_ff <= wake_tgl_ff;
        wake_s2_ff <= wake_s1_ff;
        wake_s3_ff <= wake_s2_ff;
    end

    assign req_evt  = req_s3_ff != req_s2_ff;
    assign wake_evt = wake_s3_ff != wake_s2_ff;

    adc_result_coder #(.WIDTH(RESULT_BITS)) u_coder
    (
        .i_sample  (i_sample),
        .i_bipolar (bipolar_ff),
        .o_code    (coded)
    );

    // conversion timer; control fields stay stable while the toggle crosses
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            busy_ff        <= 1'b0;
            conv_cnt_ff    <= 16'h0000;
            result_code_ff <= '0;
            pend_mode_ff   <= PWR_RESET_VAL;
            bipolar_ff     <= 1'b0;
        end
        else if (req_evt)
        begin
            busy_ff      <= 1'b1; // see RQ3
            conv_cnt_ff  <= 16'(CONV_CNT - 1);
            pend_mode_ff <= ctrl_ff.power_mode;
            bipolar_ff   <= ctrl_ff.bipolar;
        end
        else if (busy_ff)
        begin
            if (conv_cnt_ff == 16'h0000)
            begin
                busy_ff        <= 1'b0;
                result_code_ff <= coded; // see RQ4
            end
            else
                conv_cnt_ff <= conv_cnt_ff - 16'h0001;
        end
    end

    // completion toggle; kept out of reset so the link side sees no false edge
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst && !req_evt && busy_ff && conv_cnt_ff == 16'h0000)
            done_tgl_ff <= ~done_tgl_ff;
    end

    // power state: wake on start bit, sleep only after conversion ends
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            pwr_ff <= PWR_ACTIVE;
        else if (req_evt || wake_evt)
            pwr_ff <= PWR_ACTIVE; // see RQ1
        else if (busy_ff && conv_cnt_ff == 16'h0000)
        begin
            case (pend_mode_ff) // see RQ14, RQ15
                PWR_FULL_DOWN: pwr_ff <= PWR_FULL;
                PWR_FAST_DOWN: pwr_ff <= PWR_FAST;
                default:       pwr_ff <= PWR_ACTIVE;
            endcase
        end
    end

    assign o_busy      = busy_ff;
    assign o_pwr_state = pwr_ff;
    assign o_core_on   = pwr_ff == PWR_ACTIVE;        // see RQ16
    assign o_ref_on    = pwr_ff != PWR_FULL;          // see RQ16
endmodule // adc_serial_result_readout
`default_nettype wire

// ### design/adc_readout_pkg.sv
// shared constants and carrier types for the converter serial readout
`default_nettype none
package adc_readout_pkg;

    localparam int RESULT_BITS      = 14;
    localparam int CTRL_BITS        = 8;
    localparam int FRAME_BITS       = 16;
    // control byte field positions (bit 7 is the start bit)
    localparam int CTRL_START_POS   = 7;
    localparam int CTRL_BIPOLAR_POS = 2;
    localparam int CTRL_PWR_HI_POS  = 1;
    localparam int CTRL_PWR_LO_POS  = 0;
    // power mode codes from the two power-mode bits
    localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
    localparam logic [1:0] PWR_FAST_DOWN = 2'h1;
    localparam logic [1:0] PWR_RUN_INT   = 2'h2;
    localparam logic [1:0] PWR_RUN_EXT   = 2'h3;
    localparam logic [1:0] PWR_RESET_VAL = 2'h2;
    // conversion time in ns and the derived system-clock count
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int CONV_TIME_NS     = 8000;
    localparam int CONV_CYCLES      = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // host wait after wake from full power-down with internal reference
    localparam int WAKE_TIME_US     = 2000;
    localparam int WAKE_CYCLES      = (WAKE_TIME_US * 1000000) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_FAST,
        PWR_FULL
    } pwr_state_t;

    // control byte as received by the link side
    typedef struct packed {
        logic       bipolar;
        logic [1:0] power_mode;
    } ctrl_t;

    // conversion request from link to system domain
    typedef struct packed {
        logic [RESULT_BITS-1:0] sample;
        ctrl_t                  ctrl;
    } conv_req_t;

endpackage : adc_readout_pkg
`default_nettype wire

// ### design/adc_result_coder.sv
// result coder: straight binary or two's complement from a unipolar sample
`timescale 1ns/1ps
`default_nettype none
module adc_result_coder
#(
    parameter int WIDTH = adc_readout_pkg::RESULT_BITS
)
(
    input  wire logic [WIDTH-1:0] i_sample,
    input  wire logic             i_bipolar,
    output logic      [WIDTH-1:0] o_code
);
    import adc_readout_pkg::*;

    // refuse widths without a sign bit to flip
    if (WIDTH < 2)
    begin : g_bad_width
        $error("width too small");
    end

    // bipolar flips the msb: offset binary to two's complement
    always_comb
    begin
        o_code = i_sample;
        if (i_bipolar)
            o_code[WIDTH-1] = ~i_sample[WIDTH-1]; // see RQ4
    end
endmodule // adc_result_coder
`default_nettype wire

// ### verification/adc_readout_properties.sv
// port assertions for the converter serial readout
`timescale 1ns/1ps
`default_nettype none
module adc_readout_properties
#(
    parameter int CONV_CNT = 40
)
(
    input wire logic                                    i_clk_sys,
    input wire logic                                    i_rst,
    input wire logic                                    i_sclk,
    input wire logic                                    i_cs_n,
    input wire logic                                    i_din,
    input wire logic                                    o_dout,
    input wire logic                                    o_dout_oe_n,
    input wire logic [adc_readout_pkg::RESULT_BITS-1:0] i_sample,
    input wire logic                                    o_busy,
    input wire logic                                    o_ref_on,
    input wire logic                                    o_core_on,
    input var  adc_readout_pkg::pwr_state_t             o_pwr_state
);
    import adc_readout_pkg::*;
    logic [15:0] busy_cnt_ff;
    // counts system cycles of a running conversion
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !o_busy) busy_cnt_ff <= 16'h0;
        else busy_cnt_ff <= busy_cnt_ff + 16'h1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_oe_follows_cs: assert property (o_dout_oe_n == i_cs_n)
        else $error("output enable differs from select");
    a_dout_quiet: assert property (i_cs_n |-> !o_dout)
        else $error("data out not low while deselected");
    a_dout_hold_hi: assert property ((!i_cs_n && i_sclk && $past(i_sclk)) |-> $stable(o_dout))
        else $error("data out moved while serial clock high");
    a_busy_active: assert property (o_busy |-> o_pwr_state == PWR_ACTIVE)
        else $error("powered down during conversion");
    a_busy_span: assert property ($fell(o_busy) |-> busy_cnt_ff inside {[CONV_CNT:CONV_CNT+1]})
        else $error("conversion length wrong");
    a_core_power: assert property (o_core_on == (o_pwr_state == PWR_ACTIVE))
        else $error("core power does not match state");
    a_ref_power: assert property (o_ref_on == (o_pwr_state != PWR_FULL))
        else $error("reference power does not match state");
    a_pwr_cause: assert property (!$stable(o_pwr_state) |-> ($past(o_busy) || !i_cs_n))
        else $error("power state changed without cause");
    a_wake_start: assert property ((!i_cs_n && i_din && $rose(i_sclk) && o_pwr_state != PWR_ACTIVE)
        |-> ##[1:8] o_pwr_state == PWR_ACTIVE)
        else $error("no wake on start bit");
    c_full: cover property (o_pwr_state == PWR_FULL);
    c_fast: cover property (o_pwr_state == PWR_FAST);
    c_done: cover property ($fell(o_busy));
endmodule // adc_readout_properties
bind adc_serial_result_readout adc_readout_properties #(.CONV_CNT(CONV_CNT)) u_adc_readout_properties (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_din(i_din),
    .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n), .i_sample(i_sample), .o_busy(o_busy),
    .o_ref_on(o_ref_on), .o_core_on(o_core_on), .o_pwr_state(o_pwr_state));
`default_nettype wire

// ### verification/host_master_model.sv
// host serial master model driving select, clock and data in
`timescale 1ns/1ps
`default_nettype none
module host_master_model
#(
    parameter int HALF_NS = 32 // half period of the serial clock
)
(
    output var  logic o_sclk,
    output var  logic o_cs_n,
    output var  logic o_din,
    input  wire logic i_dout
);
    // clock idles low and stands still outside frames
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
    end
    // select or release; released data shows the inverse level
    task automatic sel(input logic lvl);
        o_cs_n = lvl;
        if (lvl) o_din = ~o_din;
        #(HALF_NS);
    endtask
    // n bits msb first out of tx while dout is taken on each rise
    task automatic shift(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0;
        for (int i = 0; i < n; i++)
        begin
            o_din = tx[15-i];
            #(HALF_NS) o_sclk = 1'b1;
            rx = {rx[14:0], i_dout};
            #(HALF_NS) o_sclk = 1'b0;
        end
    endtask
endmodule // host_master_model
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the converter serial readout
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adc_readout_pkg::*;
    logic       clk, sclk, cs_n, din, dout, dout_oe_n, busy, ref_on, core_on;
    logic       rst = 1'b1;
    logic [13:0] sample = 14'h0;
    pwr_state_t pwr;
    int         n_fail = 0;
    int         checked = 0;
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    adc_serial_result_readout #(.CONV_CNT(40)) u_adc_serial_result_readout (
        .i_clk_sys(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
        .o_dout(dout), .o_dout_oe_n(dout_oe_n), .i_sample(sample), .o_busy(busy),
        .o_ref_on(ref_on), .o_core_on(core_on), .o_pwr_state(pwr));
    host_master_model u_host_master_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
        .i_dout(dout));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // control byte behind zeros, conversion, readout, power check
    task automatic conv(input logic [7:0] ctrl, input logic [13:0] smp, input logic bytes,
                        input pwr_state_t exp_pwr);
        logic [13:0] code;
        logic [15:0] rx;
        logic [15:0] rx2;
        code = ctrl[CTRL_BIPOLAR_POS] ? (smp ^ 14'h2000) : smp;
        @(posedge clk);
        sample <= smp;
        #1.3; // keeps the control-byte link edges and the two checks after them off the system clock edges
        u_host_master_model.sel(1'b0);
        u_host_master_model.shift({4'h0, ctrl, 4'h0}, 12, rx);
        // external reference assumed: no settle wait after the wake
        chk(16'(pwr), 16'(PWR_ACTIVE));
        chk(16'(busy), 16'h1);
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
        chk(16'(busy), 16'h0);
        u_host_master_model.shift(16'h0, 4, rx);
        if (bytes)
        begin
            u_host_master_model.shift(16'h0, 8, rx);
            u_host_master_model.shift(16'h0, 8, rx2);
            chk(rx, {8'h0, code[13:6]});
            chk(rx2, {8'h0, code[5:0], 2'b00});
        end
        else
        begin
            u_host_master_model.shift(16'h0, 16, rx);
            chk(rx, {code, 2'b00});
        end
        chk(16'(pwr), 16'(exp_pwr));
        chk({14'h0, ref_on, core_on}, {14'h0, exp_pwr != PWR_FULL, exp_pwr == PWR_ACTIVE});
        chk(16'(dout_oe_n), 16'h0);
        u_host_master_model.sel(1'b1);
    endtask
    task automatic t_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({12'h0, busy, ref_on, core_on, dout_oe_n}, 16'h7);
        chk(16'(pwr), 16'(PWR_ACTIVE));
        $display("reset test done");
    endtask
    task automatic t_unipolar_word();
        conv(8'h82, 14'h2a5b, 1'b0, PWR_ACTIVE);
        $display("unipolar word test done");
    endtask
    task automatic t_bipolar_bytes();
        conv(8'h87, 14'h0123, 1'b1, PWR_ACTIVE);
        $display("bipolar byte test done");
    endtask
    task automatic t_power_modes();
        conv(8'h81, 14'h3fff, 1'b1, PWR_FAST);
        conv(8'h83, 14'h1000, 1'b0, PWR_ACTIVE);
        conv(8'h80, 14'h0001, 1'b1, PWR_FULL);
        conv(8'h85, 14'h2000, 1'b0, PWR_FAST);
        $display("power mode test done");
    endtask
    initial
    begin
        #60000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        t_reset();
        t_unipolar_word();
        t_power_modes();
        t_reset();
        t_bipolar_bytes();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
